/* nic_consts.svh */
/*
  Constants of the nested interrupt controller: priority encodings, vector
  addresses, condition code bit positions, reset values and source counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef NIC_CONSTS_SVH
`define NIC_CONSTS_SVH

// ********************************************************************
// Level encodings and condition code positions
// ********************************************************************
`define NIC_LVL0        2'b10
`define NIC_LVL1        2'b01
`define NIC_LVL2        2'b00
`define NIC_LVL3        2'b11
`define NIC_CC_HI_POS   5
`define NIC_CC_LO_POS   3

// ********************************************************************
// Vector map and counts
// ********************************************************************
`define NIC_VEC_RESET   16'hfffe
`define NIC_VEC_TRAP    16'hfffc
`define NIC_VEC_BASE    16'hfffa
`define NIC_NUM_VEC     14
`define NIC_NUM_EXT     5
`define NIC_NUM_PER     8
`define NIC_PINS_GRP    4
`define NIC_HALT_WAKE   14'h01ff
`define NIC_STACK_LAST  2'h3
`define NIC_PRIO_RST    8'hff
`define NIC_PRIO_REGS   4

`endif

/* nic_core_model.sv */
/*
  Core sequencer model: instruction boundaries and stack push acknowledges.
  Assumes the nic_ctrl stacking handshake, all on sys_clk.
*/
`timescale 1ns/1ps
module nic_core_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rstn,
  // Bench control
  input  wire logic run,
  input  wire logic slow,
  // Controller side
  input  wire logic stackReq,
  output logic      instrEnd,
  output logic      stackAck
);
  logic ph;

  initial begin
    instrEnd = 1'b0;
    stackAck = 1'b0;
    ph       = 1'b0;
  end

  // Slow mode acks every other cycle, so a push may wait on the core
  always @(posedge sys_clk) begin
    #5;
    ph       = ~ph;
    instrEnd = run & rstn;
    stackAck = stackReq & (~slow | ph);
  end
endmodule : nic_core_model

/* nic_ctrl.sv */
/*
  Nested interrupt controller top: request latching, two-step arbitration,
  stacking and vector sequence, current level bits and wake-up decision.
  Assumes the core pulses instrEnd at each instruction boundary, acknowledges
  each stack push, and reports return, trap and level writes as pulses.
*/
`timescale 1ns/1ps
`include "nic_consts.svh"
module nic_ctrl
  import nic_pkg::*;
#(
  parameter int          NGRP      = `NIC_NUM_EXT,
  parameter int          NPER      = `NIC_NUM_PER,
  parameter int          PPG       = `NIC_PINS_GRP,
  parameter logic [13:0] HALT_WAKE = `NIC_HALT_WAKE
) (
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                rstn,
  // Dedicated non-maskable pin, falling edge
  input  wire logic                nmiPinN,
  // External pin groups and sensitivity
  input  wire logic [NGRP*PPG-1:0] extPins,
  input  wire logic [NGRP*PPG-1:0] extSelect,
  input  wire logic [NGRP-1:0]     extEdgeMode,
  input  wire logic [NGRP-1:0]     extFalling,
  // Peripheral sources
  input  wire logic [NPER-1:0]     perFlag,
  input  wire logic [NPER-1:0]     perEnable,
  input  wire logic [NPER-1:0]     perClear,
  // Core sequencer
  input  wire logic                instrEnd,
  input  wire logic                trapExec,
  input  wire logic                iretDone,
  input  wire nic_level_t          iretLevel,
  input  wire logic                ccWrite,
  input  wire nic_level_t          ccWrLevel,
  input  wire logic                haltMode,
  input  wire logic                waitMode,
  input  wire logic                stackAck,
  output logic                     stackReq,
  output logic      [1:0]          stackSel,
  output logic                     vectorLoad,
  output nic_svc_t                 svcOut,
  output nic_level_t               ccLevel,
  output logic      [7:0]          ccImage,
  output logic                     wakeUp,
  output logic                     busy,
  // Level register access
  input  wire logic                prioWrEn,
  input  wire logic [1:0]          prioWrIdx,
  input  wire logic [7:0]          prioWrData,
  input  wire logic [1:0]          prioRdIdx,
  output logic      [7:0]          prioRdData
);

  localparam int NV = 1 + NGRP + NPER;

  initial begin
    if (NV != `NIC_NUM_VEC) $error("nic_ctrl: source counts do not fill the vector map");
    if (PPG < 1) $error("nic_ctrl: group needs at least one pin");
  end

  // ********************************************************************
  // Pin synchronisers
  // ********************************************************************
  logic                nmiMeta_r, nmiSync_r, nmiPrev_r;
  logic [NGRP*PPG-1:0] extMeta_r, extSync_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nmiMeta_r <= 1'b1;
      nmiSync_r <= 1'b1;
      nmiPrev_r <= 1'b1;
      extMeta_r <= '0;
      extSync_r <= '0;
    end else begin
      nmiMeta_r <= nmiPinN;
      nmiSync_r <= nmiMeta_r;
      nmiPrev_r <= nmiSync_r;
      extMeta_r <= extPins;
      extSync_r <= extMeta_r;
    end
  end

  // ********************************************************************
  // Arbitration and sequencer signals
  // ********************************************************************
  nic_state_t        state_r;
  logic [NV-1:0]     pend;
  logic [2*NV-1:0]   levels;
  logic              nmiLatch_r, trapLatch_r, haltFirst_r;
  logic [NGRP-1:0]   grpAct, grpPrev_r, extLatch_r;
  logic [NPER-1:0]   perLatch_r;
  logic              found, winTrap, take;
  logic [3:0]        winIdx;
  logic [2:0]        winRank, curRank;
  logic [NV-1:0]     wakeMask;
  logic [1:0]        stackCnt_r;
  nic_svc_t          svc_nxt;
  logic              selMaskable_r;

  assign take = (state_r == NIC_IDLE) && instrEnd && found && !haltMode;

  // ********************************************************************
  // Request latches
  // ********************************************************************
  wire nmiEdge = nmiPrev_r && !nmiSync_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      nmiLatch_r <= 1'b0;
    end else if (nmiEdge) begin
      nmiLatch_r <= 1'b1;
    end else if (take && !winTrap && winIdx == 4'h0) begin
      nmiLatch_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      trapLatch_r <= 1'b0;
    end else if (trapExec) begin
      trapLatch_r <= 1'b1;
    end else if (take && winTrap) begin
      trapLatch_r <= 1'b0;
    end
  end

  for (genvar g = 0; g < NGRP; g++) begin : g_ext
    wire [PPG-1:0] pins = extSync_r[g*PPG+:PPG];
    wire [PPG-1:0] sel  = extSelect[g*PPG+:PPG];
    // Pins of a group share one line
    assign grpAct[g] = extFalling[g] ? |(~pins & sel) : |(pins & sel);
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        // Starts high so a falling group, active while the synchronisers reset low, is no edge
        grpPrev_r[g]  <= 1'b1;
        extLatch_r[g] <= 1'b0;
      end else begin
        grpPrev_r[g] <= grpAct[g];
        // A new edge in the entry cycle survives
        if (grpAct[g] && !grpPrev_r[g]) begin
          extLatch_r[g] <= 1'b1;
        end else if (take && !winTrap && winIdx == 4'(g + 1)) begin
          extLatch_r[g] <= 1'b0;
        end
      end
    end
    assign pend[g+1] = extEdgeMode[g] ? extLatch_r[g] : grpAct[g];
  end

  for (genvar p = 0; p < NPER; p++) begin : g_per
    wire perReq = perFlag[p] && perEnable[p];
    always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
        perLatch_r[p] <= 1'b0;
      end else if (perReq) begin
        perLatch_r[p] <= 1'b1;
      end else if (perClear[p]) begin
        perLatch_r[p] <= 1'b0;
      end
    end
    assign pend[p+1+NGRP] = perLatch_r[p];
  end

  assign pend[0] = nmiLatch_r;

  // ********************************************************************
  // Two-step arbitration
  // ********************************************************************
  assign curRank  = nic_rank(ccLevel);
  assign wakeMask = haltFirst_r ? HALT_WAKE : {NV{1'b1}};

  always_comb begin
    logic [2:0] r;
    logic       elig;
    r       = 3'h0;
    elig    = 1'b0;
    found   = 1'b0;
    winIdx  = 4'h0;
    winRank = 3'h0;
    // Lowest hardware order first; ties move to the lower index
    for (int i = NV - 1; i >= 0; i--) begin
      r = (i == 0) ? 3'h4 : nic_rank(levels[2*i+:2]);
      // A raised level of a pending running vector re-enters here
      elig = pend[i] && wakeMask[i] && (i == 0 || r > curRank);
      if (elig && (!found || r >= winRank)) begin
        found   = 1'b1;
        winIdx  = 4'(i);
        winRank = r;
      end
    end
    winTrap = trapLatch_r && !haltFirst_r;
    if (winTrap) begin
      found = 1'b1;
    end
  end

  always_comb begin
    svc_nxt.addr = `NIC_VEC_BASE - {11'h0, winIdx, 1'b0};
    svc_nxt.lvl  = levels[2*winIdx+:2];
    if (winTrap) begin
      svc_nxt.addr = `NIC_VEC_TRAP;
      svc_nxt.lvl  = `NIC_LVL3;
    end else if (winIdx == 4'h0) begin
      svc_nxt.lvl  = `NIC_LVL3;
    end
  end

  // ********************************************************************
  // Entry sequencer
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= NIC_BOOT;
    end else begin
      unique case (state_r)
        NIC_BOOT:  state_r <= NIC_FETCH;
        NIC_IDLE:  if (take) state_r <= NIC_STACK;
        NIC_STACK: if (stackAck && stackCnt_r == `NIC_STACK_LAST) state_r <= NIC_FETCH;
        NIC_FETCH: state_r <= NIC_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      stackCnt_r <= 2'h0;
    end else if (state_r != NIC_STACK) begin
      stackCnt_r <= 2'h0;
    end else if (stackAck) begin
      stackCnt_r <= stackCnt_r + 2'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      svcOut        <= '{addr: `NIC_VEC_RESET, lvl: `NIC_LVL3};
      selMaskable_r <= 1'b0;
    end else if (take) begin
      svcOut        <= svc_nxt;
      selMaskable_r <= !winTrap && winIdx != 4'h0;
    end
  end

  // Stack order: PC, X, A, CC
  assign stackReq   = (state_r == NIC_STACK);
  assign stackSel   = stackCnt_r;
  assign vectorLoad = (state_r == NIC_FETCH);
  assign busy       = (state_r != NIC_IDLE);

  // ********************************************************************
  // Current level bits
  // ********************************************************************
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      ccLevel <= `NIC_LVL3;
    end else if (state_r == NIC_FETCH) begin
      ccLevel <= svcOut.lvl;
    end else if (iretDone) begin
      ccLevel <= iretLevel;
    end else if (ccWrite) begin
      ccLevel <= ccWrLevel;
    end
  end

  always_comb begin
    ccImage                 = 8'h00;
    ccImage[`NIC_CC_HI_POS] = ccLevel.hi;
    ccImage[`NIC_CC_LO_POS] = ccLevel.lo;
  end

  // ********************************************************************
  // Low power wake-up
  // ********************************************************************
  // Any waking request ends halt; trap cannot arise while halted
  assign wakeUp = (waitMode && (|pend || trapLatch_r))
                || (haltMode && |(pend & HALT_WAKE));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      haltFirst_r <= 1'b0;
    end else if (haltMode && wakeUp) begin
      haltFirst_r <= 1'b1;
    end else if (take) begin
      haltFirst_r <= 1'b0;
    end
  end

  nic_level_regs #(.NV(NV)) u_levels (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .wrEn    (prioWrEn),
    .wrIdx   (prioWrIdx),
    .wrData  (prioWrData),
    .rdIdx   (prioRdIdx),
    .rdData  (prioRdData),
    .levels  (levels)
  );

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_nmi_latch: assert property (@(posedge sys_clk) disable iff (!rstn)
    nmiEdge |=> nmiLatch_r)
    else $error("pin edge not latched");
  a_entry_level: assert property (@(posedge sys_clk) disable iff (!rstn)
    vectorLoad |=> ccLevel == $past(svcOut.lvl))
    else $error("level not loaded on entry");
  a_nonmask_lvl3: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && (winTrap || winIdx == 4'h0) |=> svcOut.lvl == `NIC_LVL3)
    else $error("non-maskable entry not at level 3");
  // Fetch only after the last of the four pushes was acknowledged
  a_four_pushes: assert property (@(posedge sys_clk) disable iff (!rstn)
    vectorLoad && !$past(state_r == NIC_BOOT) |-> $past(stackAck && stackSel == `NIC_STACK_LAST))
    else $error("entry fetched before the fourth push");
  a_return_from_handler_restore: assert property (@(posedge sys_clk) disable iff (!rstn)
    iretDone && !vectorLoad |=> ccLevel == $past(iretLevel))
    else $error("return did not restore level");
  a_mask_gate: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && !winTrap && winIdx != 4'h0 |-> nic_rank(levels[2*winIdx+:2]) > curRank)
    else $error("maskable taken at or below level");
  a_halt_first: assert property (@(posedge sys_clk) disable iff (!rstn)
    take && haltFirst_r |-> HALT_WAKE[winIdx] && !winTrap)
    else $error("non-waking source served first after halt");
  a_wait_wake: assert property (@(posedge sys_clk) disable iff (!rstn)
    waitMode && |pend |-> wakeUp)
    else $error("pending request did not end wait");
  a_boot_vector: assert property (@(posedge sys_clk) disable iff (!rstn)
    state_r == NIC_BOOT |=> vectorLoad && svcOut.addr == `NIC_VEC_RESET)
    else $error("boot did not fetch reset vector");
  a_per_clear: assert property (@(posedge sys_clk) disable iff (!rstn)
    perClear[0] && !(perFlag[0] && perEnable[0]) |=> !perLatch_r[0])
    else $error("clear did not discard request");

  c_nmi_taken:  cover property (@(posedge sys_clk) disable iff (!rstn)
    take && !winTrap && winIdx == 4'h0);
  c_nested:     cover property (@(posedge sys_clk) disable iff (!rstn)
    take && selMaskable_r && curRank != 3'h0);
  c_halt_exit:  cover property (@(posedge sys_clk) disable iff (!rstn)
    take && haltFirst_r);
  c_trap_taken: cover property (@(posedge sys_clk) disable iff (!rstn)
    take && winTrap);

endmodule : nic_ctrl

/* nic_level_regs.sv */
/*
  Per-vector software level registers, four bytes, two bits per vector.
  Assumes writes and reads come from core logic on sys_clk.
*/
`timescale 1ns/1ps
`include "nic_consts.svh"
module nic_level_regs
  import nic_pkg::*;
#(
  parameter int NV = `NIC_NUM_VEC
) (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rstn,
  // Register access
  input  wire logic            wrEn,
  input  wire logic [1:0]      wrIdx,
  input  wire logic [7:0]      wrData,
  input  wire logic [1:0]      rdIdx,
  output logic      [7:0]      rdData,
  // Levels of all vectors
  output logic      [2*NV-1:0] levels
);

  logic [7:0] regs_r [`NIC_PRIO_REGS];
  logic [7:0] roMask;

  initial begin
    if (NV > 4 * `NIC_PRIO_REGS) $error("nic_level_regs: too many vectors");
  end

  // Top register keeps unused fields at ones
  assign roMask = (wrIdx == 2'h3) ? 8'hf0 : 8'h00;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      for (int r = 0; r < `NIC_PRIO_REGS; r++) begin
        regs_r[r] <= `NIC_PRIO_RST;
      end
    end else if (wrEn) begin
      for (int f = 0; f < 4; f++) begin
        if (wrData[2*f+:2] != `NIC_LVL0 && !roMask[2*f]) begin
          regs_r[wrIdx][2*f+:2] <= wrData[2*f+:2];
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rdData <= `NIC_PRIO_RST;
    end else begin
      rdData <= regs_r[rdIdx];
    end
  end

  for (genvar v = 0; v < NV; v++) begin : g_lvl
    assign levels[2*v+:2] = regs_r[v/4][2*(v%4)+:2];
  end

  a_zero_ignored: assert property (@(posedge sys_clk) disable iff (!rstn)
    wrEn && wrIdx == 2'h0 && wrData[1:0] == `NIC_LVL0
    |=> regs_r[0][1:0] == $past(regs_r[0][1:0]))
    else $error("level 0 write changed a field");

endmodule : nic_level_regs

/* nic_pkg.sv */
/*
  Types shared by the nested interrupt controller modules.
  Assumes the constants header is on the include path.
*/
`include "nic_consts.svh"
package nic_pkg;

  typedef struct packed {
    logic hi;
    logic lo;
  } nic_level_t;

  typedef struct packed {
    logic [15:0] addr;
    nic_level_t  lvl;
  } nic_svc_t;

  typedef enum logic [3:0] {
    NIC_BOOT  = 4'b0001,
    NIC_IDLE  = 4'b0010,
    NIC_STACK = 4'b0100,
    NIC_FETCH = 4'b1000
  } nic_state_t;

  // Ascending rank 0..3 of a level code
  function automatic logic [2:0] nic_rank(input nic_level_t l);
    logic [2:0] r;
    r = 3'h3;
    unique case ({l.hi, l.lo})
      `NIC_LVL0: r = 3'h0;
      `NIC_LVL1: r = 3'h1;
      `NIC_LVL2: r = 3'h2;
      `NIC_LVL3: r = 3'h3;
    endcase
    return r;
  endfunction : nic_rank

endpackage : nic_pkg

/* test_nic_ctrl.sv */
/*
  Self-checking bench of nic_ctrl with a core model on the stacking side.
  Assumes default parameters: 5 groups of 4 pins, 8 peripherals.
*/
`timescale 1ns/1ps
module test_nic_ctrl;
  import nic_pkg::*;
  logic        sys_clk = 1'b0, rstn = 1'b0, nmiPinN = 1'b1;
  logic [19:0] extPins = '0, extSelect = '1;
  logic [4:0]  extEdgeMode = '0, extFalling = '0;
  logic [7:0]  perFlag = '0, perEnable = '0, perClear = '0, prioWrData = '0;
  logic        trapExec = 0, iretDone = 0, ccWrite = 0, haltMode = 0, waitMode = 0;
  logic        prioWrEn = 0, run = 0, slow = 0;
  nic_level_t  iretLevel = '0, ccWrLevel = '0, ccLevel;
  logic [1:0]  prioWrIdx = '0, prioRdIdx = '0, stackSel;
  logic [7:0]  ccImage, prioRdData;
  logic        instrEnd, stackAck, stackReq, vectorLoad, wakeUp, busy;
  nic_svc_t    svcOut;
  logic [1:0]  lv [14];
  int          n_fail = 0, checks = 0, a, b, w, o, g;

  always #25 sys_clk = ~sys_clk;

  nic_ctrl uut (.sys_clk, .rstn, .nmiPinN, .extPins, .extSelect, .extEdgeMode, .extFalling,
    .perFlag, .perEnable, .perClear, .instrEnd, .trapExec, .iretDone, .iretLevel, .ccWrite,
    .ccWrLevel, .haltMode, .waitMode, .stackAck, .stackReq, .stackSel, .vectorLoad, .svcOut,
    .ccLevel, .ccImage, .wakeUp, .busy, .prioWrEn, .prioWrIdx, .prioWrData, .prioRdIdx,
    .prioRdData);
  nic_core_model core (.sys_clk, .rstn, .run, .slow, .stackReq, .instrEnd, .stackAck);

  // ********************************************************************
  // Checking and expectation helpers
  // ********************************************************************
  task automatic print_verdict;
    if (n_fail == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  function automatic int rk(input logic [1:0] c);
    return (c == 2'b10) ? 0 : (c == 2'b01) ? 1 : (c == 2'b00) ? 2 : 3;
  endfunction : rk

  function automatic logic [7:0] regval(input int r);
    logic [7:0] d;
    d = 8'hff;
    for (int f = 0; f < 4; f++)
      if (4 * r + f < 14) d[2*f+:2] = lv[4*r+f];
    return d;
  endfunction : regval

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : tick

  // ********************************************************************
  // Stimulus tasks
  // ********************************************************************
  task automatic wr_level(input int r, input logic [7:0] d);
    prioWrIdx  = 2'(r);
    prioWrData = d;
    prioWrEn   = 1'b1;
    tick(1);
    prioWrEn = 1'b0;
    tick(1);
    for (int f = 0; f < 4; f++)
      if (4 * r + f < 14 && d[2*f+:2] != 2'b10) lv[4*r+f] = d[2*f+:2];
  endtask : wr_level

  task automatic rd_level(input int r, input logic [7:0] e);
    prioRdIdx = 2'(r);
    tick(1);
    chk(prioRdData, e);
  endtask : rd_level

  task automatic set_lvl(input int v, input logic [1:0] c);
    lv[v] = c;
    wr_level(v / 4, regval(v / 4));
  endtask : set_lvl

  task automatic cc(input logic [1:0] c);
    ccWrLevel = c;
    ccWrite   = 1'b1;
    tick(1);
    ccWrite = 1'b0;
  endtask : cc

  task automatic return_from_handler(input logic [1:0] c);
    iretLevel = c;
    iretDone  = 1'b1;
    tick(1);
    iretDone = 1'b0;
    tick(1);
    chk(ccLevel, c);
  endtask : return_from_handler

  task automatic clr(input int v);
    perFlag[v-6]  = 1'b0;
    perClear[v-6] = 1'b1;
    tick(1);
    perClear = '0;
    tick(1);
  endtask : clr

  // Runs the core until one entry completes, checking push order and vector
  task automatic expect_entry(input logic [15:0] ad, input logic [1:0] l, input int np);
    int n;
    logic hit;
    n    = 0;
    hit  = 1'b0;
    slow = 1'($urandom);
    run  = 1'b1;
    for (int i = 0; i < 60 && !hit; i++) begin
      @(negedge sys_clk);
      if (stackReq === 1'b1 && stackAck === 1'b1) begin
        chk(stackSel, 16'(n));
        n++;
      end
      hit = (vectorLoad === 1'b1);
    end
    run = 1'b0;
    if (!hit) begin
      n_fail++;
      print_verdict();
    end
    chk(svcOut.addr, ad);
    chk(svcOut.lvl, l);
    chk(16'(n), 16'(np));
    chk(busy, 1'b1);
    tick(1);
    chk(ccLevel, l);
    chk(busy, 1'b0);
    chk(ccImage, {2'b00, l[1], 1'b0, l[0], 3'b000});
  endtask : expect_entry

  task automatic no_entry;
    logic bad;
    bad = 1'b0;
    run = 1'b1;
    repeat (10) begin
      @(negedge sys_clk);
      bad |= (stackReq !== 1'b0);
    end
    run = 1'b0;
    tick(1);
    chk({15'h0, bad}, 16'h0);
  endtask : no_entry

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    a = $urandom(4913);
    for (int v = 0; v < 14; v++) lv[v] = 2'b11;
    tick(5);
    rstn = 1'b1;
    chk(ccImage, 8'h28);
    expect_entry(16'hfffe, 2'b11, 0);
    for (int r = 0; r < 4; r++) rd_level(r, 8'hff);
    wr_level(0, 8'h64);
    rd_level(0, 8'h74);
    wr_level(3, 8'h00);
    rd_level(3, 8'hf0);
    // Masked by enable, then by level, then taken once level drops
    set_lvl(6, 2'b00);
    perFlag[0] = 1'b1;
    cc(2'b10);
    no_entry();
    perEnable = '1;
    cc(2'b11);
    no_entry();
    cc(2'b01);
    expect_entry(16'hffee, 2'b00, 4);
    clr(6);
    return_from_handler(2'b01);
    // Two pending peripherals; the loser must follow after return
    repeat (8) begin
      a = 6 + $urandom % 8;
      b = 6 + (a - 5 + $urandom % 7) % 8;
      g = $urandom % 3;
      set_lvl(a, (g == 2) ? 2'b11 : 2'(g));
      g = $urandom % 3;
      set_lvl(b, (g == 2) ? 2'b11 : 2'(g));
      w = (rk(lv[a]) > rk(lv[b]) || (rk(lv[a]) == rk(lv[b]) && a < b)) ? a : b;
      o = a + b - w;
      cc(2'b10);
      perFlag = 8'((1 << (a - 6)) | (1 << (b - 6)));
      expect_entry(16'hfffa - 16'(2 * w), lv[w], 4);
      clr(w);
      return_from_handler(2'b10);
      expect_entry(16'hfffa - 16'(2 * o), lv[o], 4);
      clr(o);
      return_from_handler(2'b10);
    end
    // Clearing sequence discards a masked pending request
    cc(2'b11);
    perFlag[3] = 1'b1;
    tick(2);
    clr(9);
    cc(2'b10);
    no_entry();
    // Edge latch on one selected pin of a random group
    g = $urandom % 5;
    b = $urandom % 2;
    // Group deselected while polarity and idle level settle, so no false edge
    extSelect[4*g+:4] = 4'h0;
    extPins[4*g+:4]   = {4{1'(b)}};
    extFalling[g]     = 1'(b);
    extEdgeMode[g]    = 1'b1;
    tick(3);
    extSelect[4*g+:4] = 4'hf;
    tick(1);
    a = 4 * g + $urandom % 4;
    extPins[a] = ~1'(b);
    tick(2);
    extPins[a] = 1'(b);
    tick(4);
    expect_entry(16'hfffa - 16'(2 * (g + 1)), lv[g+1], 4);
    return_from_handler(2'b10);
    no_entry();
    // Wake decisions, then halt exit serving the waking vector first
    set_lvl(9, 2'b11);
    set_lvl(6, 2'b01);
    perFlag = 8'h09;
    waitMode = 1'b1;
    tick(1);
    chk(wakeUp, 1);
    waitMode = 1'b0;
    clr(6);
    haltMode = 1'b1;
    tick(1);
    chk(wakeUp, 0);
    perFlag = 8'h09;
    tick(1);
    chk(wakeUp, 1);
    // One more halted edge lets the controller note the halt exit
    tick(1);
    haltMode = 1'b0;
    expect_entry(16'hffee, 2'b01, 4);
    expect_entry(16'hffe8, 2'b11, 4);
    clr(9);
    clr(6);
    return_from_handler(2'b01);
    return_from_handler(2'b10);
    // Pin edge wakes halt; trap is held back until after the pin request
    cc(2'b11);
    haltMode = 1'b1;
    nmiPinN = 1'b0;
    tick(5);
    chk(wakeUp, 1);
    haltMode = 1'b0;
    trapExec = 1'b1;
    tick(1);
    trapExec = 1'b0;
    expect_entry(16'hfffa, 2'b11, 4);
    expect_entry(16'hfffc, 2'b11, 4);
    return_from_handler(2'b11);
    return_from_handler(2'b11);
    nmiPinN = 1'b1;
    print_verdict();
  end
endmodule : test_nic_ctrl
